// ==== data_space_access.sv ====
// data space access unit: decode, byte lanes, alignment trap, x/y read paths
// ==========================================================
`default_nettype none
`include "data_space_defs.svh"

module data_space_access (
  input wire logic clk,
  input wire logic rstn,
  input wire data_space_pkg::gen_req_t x_rd_req,
  input wire data_space_pkg::gen_req_t y_rd_req,
  input wire data_space_pkg::gen_req_t wr_req,
  input wire logic [15:0] wr_data,
  input wire logic wr_bitrev,
  input wire logic [`ADDR_W-1:0] wr_bitrev_next,
  input wire logic [15:0] wreg_old,
  input wire logic ctl_rd_hit,
  input wire logic [15:0] ctl_rd_data,
  input wire data_space_pkg::widen_req_t widen_req,
  output logic x_rd_valid,
  output logic [15:0] x_rd_data,
  output logic [15:0] x_load_value,
  output logic x_window_hit,
  output logic [`ADDR_W-1:0] x_next_ptr,
  output logic y_rd_valid,
  output logic [15:0] y_rd_data,
  output logic [`ADDR_W-1:0] y_next_ptr,
  output logic wr_done,
  output logic [`ADDR_W-1:0] wr_next_ptr,
  output data_space_pkg::ctl_wr_t ctl_wr,
  output logic addr_error,
  output logic addr_error_is_write,
  output logic widen_valid,
  output logic [15:0] widen_result
);

  // ==========================================================
  // storage: two byte-wide arrays, shared word index
  logic [7:0] mem_lo [`RAM_WORDS];
  logic [7:0] mem_hi [`RAM_WORDS];

  // ==========================================================
  // address generators: x read, y read, write
  data_space_pkg::gen_res_t x_res;
  data_space_pkg::gen_res_t y_res;
  data_space_pkg::gen_res_t w_res;

  address_generator #(.ALLOW_BITREV(1'b0)) u_x_rd_gen (
    .req(x_rd_req),
    .bitrev_req(1'b0),
    .bitrev_next(`DATA_RST),
    .res(x_res)
  );

  address_generator #(.ALLOW_BITREV(1'b0)) u_y_rd_gen (
    .req(y_rd_req),
    .bitrev_req(1'b0),
    .bitrev_next(`DATA_RST),
    .res(y_res)
  );

  address_generator #(.ALLOW_BITREV(1'b1)) u_wr_gen (
    .req(wr_req),
    .bitrev_req(wr_bitrev),
    .bitrev_next(wr_bitrev_next),
    .res(w_res)
  );

  // ==========================================================
  // x read path over the unified space
  wire logic [`ADDR_W-1:0] x_addr = x_res.effective_address;
  wire logic [`RAM_IDX_W-1:0] x_idx = x_addr[`RAM_IDX_W:1];
  wire logic x_in_ram = (x_res.region == data_space_pkg::REGION_RAM);
  wire logic x_in_ctl = (x_res.region == data_space_pkg::REGION_CTL);
  wire logic x_in_win = (x_res.region == data_space_pkg::REGION_WINDOW);
  wire logic [15:0] x_ram_word = {mem_hi[x_idx], mem_lo[x_idx]};
  wire logic [15:0] x_ctl_word = ctl_rd_hit ? ctl_rd_data : `DATA_RST;
  wire logic [15:0] x_word =
    x_in_ram ? x_ram_word :
    x_in_ctl ? x_ctl_word :
    `DATA_RST;
  wire logic [15:0] x_value = data_space_pkg::pick_lane(x_word, x_rd_req.size, x_addr[0]);
  wire logic x_is_byte = (x_rd_req.size == data_space_pkg::SIZE_BYTE);
  wire logic [15:0] x_load = x_is_byte ? {wreg_old[15:8], x_value[7:0]} : x_value;

  // ==========================================================
  // y read path: only inside the fixed y range
  wire logic [`ADDR_W-1:0] y_addr = y_res.effective_address;
  wire logic [`RAM_IDX_W-1:0] y_idx = y_addr[`RAM_IDX_W:1];
  wire logic y_in_y = (y_res.region == data_space_pkg::REGION_RAM) && (y_addr >= `Y_BASE);
  wire logic [15:0] y_word = y_in_y ? {mem_hi[y_idx], mem_lo[y_idx]} : `DATA_RST;
  wire logic [15:0] y_value = data_space_pkg::pick_lane(y_word, y_rd_req.size, y_addr[0]);

  // ==========================================================
  // write path: unified decode, per-lane strobes
  wire logic [`ADDR_W-1:0] w_addr = w_res.effective_address;
  wire logic [`RAM_IDX_W-1:0] w_idx = w_addr[`RAM_IDX_W:1];
  wire logic w_is_word = (wr_req.size == data_space_pkg::SIZE_WORD);
  wire logic w_ok = wr_req.valid && !w_res.misaligned;
  wire logic w_lo_lane = w_is_word || !w_addr[0];
  wire logic w_hi_lane = w_is_word || w_addr[0];
  wire logic w_to_ram = w_ok && (w_res.region == data_space_pkg::REGION_RAM);
  wire logic w_to_ctl = w_ok && (w_res.region == data_space_pkg::REGION_CTL);
  wire logic [7:0] w_lo_byte = wr_data[7:0];
  wire logic [7:0] w_hi_byte = w_is_word ? wr_data[15:8] : wr_data[7:0];
  wire logic [15:0] w_lane_data = {w_hi_byte, w_lo_byte};

  // ==========================================================
  // alignment trap event, direction qualified
  wire logic x_mis = x_rd_req.valid && x_res.misaligned;
  wire logic y_mis = y_rd_req.valid && y_res.misaligned;
  wire logic w_mis = wr_req.valid && w_res.misaligned;
  wire logic error_next = x_mis || y_mis || w_mis;

  // ==========================================================
  // widen operations
  wire logic [15:0] widen_next =
    (widen_req.op == data_space_pkg::WIDEN_SIGN) ?
    {{8{widen_req.value[7]}}, widen_req.value[7:0]} :
    {8'h00, widen_req.value[7:0]};

  // ==========================================================
  // memory writes; lanes written independently
  always_ff @(posedge clk) begin
    if (w_to_ram && w_lo_lane) begin
      mem_lo[w_idx] <= w_lane_data[7:0];
    end
    if (w_to_ram && w_hi_lane) begin
      mem_hi[w_idx] <= w_lane_data[15:8];
    end
  end

  // ==========================================================
  // x read bus registers; misaligned read still completes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      x_rd_valid <= 1'b0;
      x_rd_data <= `DATA_RST;
      x_load_value <= `DATA_RST;
      x_window_hit <= 1'b0;
      x_next_ptr <= `DATA_RST;
    end else begin
      x_rd_valid <= x_rd_req.valid;
      x_rd_data <= x_rd_req.valid ? x_value : `DATA_RST;
      x_load_value <= x_load;
      x_window_hit <= x_rd_req.valid && x_in_win;
      x_next_ptr <= x_res.next_pointer;
    end
  end

  // ==========================================================
  // y read bus registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      y_rd_valid <= 1'b0;
      y_rd_data <= `DATA_RST;
      y_next_ptr <= `DATA_RST;
    end else begin
      y_rd_valid <= y_rd_req.valid;
      y_rd_data <= y_rd_req.valid ? y_value : `DATA_RST;
      y_next_ptr <= y_res.next_pointer;
    end
  end

  // ==========================================================
  // write bus status and control register strobes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_done <= 1'b0;
      wr_next_ptr <= `DATA_RST;
      ctl_wr <= '0;
    end else begin
      wr_done <= wr_req.valid;
      wr_next_ptr <= w_res.next_pointer;
      ctl_wr.strobe_lo <= w_to_ctl && w_lo_lane;
      ctl_wr.strobe_hi <= w_to_ctl && w_hi_lane;
      ctl_wr.addr <= w_addr;
      ctl_wr.data <= w_lane_data;
    end
  end

  // ==========================================================
  // trap event and widen result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_error <= 1'b0;
      addr_error_is_write <= 1'b0;
      widen_valid <= 1'b0;
      widen_result <= `DATA_RST;
    end else begin
      addr_error <= error_next;
      addr_error_is_write <= w_mis;
      widen_valid <= widen_req.valid;
      widen_result <= widen_req.valid ? widen_next : `DATA_RST;
    end
  end

endmodule // data_space_access

`default_nettype wire

// ==== data_space_defs.svh ====
// constants for the data space access unit
`ifndef DATA_SPACE_DEFS_SVH
`define DATA_SPACE_DEFS_SVH

// ==========================================================
// address space
`define ADDR_W 16
`define SPACE_BYTES 65536
`define SPACE_WORDS 32768
`define WINDOW_BIT 15
`define CTL_BASE 16'h0000
`define CTL_END 16'h07ff
`define NEAR_END 16'h1fff
`define NEAR_FIELD_W 13
`define RAM_END 16'h77ff
`define RAM_WORDS 15360
`define RAM_IDX_W 14
`define Y_BASE 16'h4800

// ==========================================================
// pointer steps
`define BYTE_STEP 16'h0001
`define WORD_STEP 16'h0002

// ==========================================================
// reset values
`define DATA_RST 16'h0000

`endif

// ==== data_space_pkg.sv ====
// types and shared decode functions for the data space access unit
`default_nettype none
`include "data_space_defs.svh"

package data_space_pkg;

  // ==========================================================
  // enumerations
  typedef enum logic {SIZE_BYTE, SIZE_WORD} access_size_t;
  typedef enum logic [1:0] {MODE_INDIRECT, MODE_POSTINC, MODE_DIRECT_NEAR,
                            MODE_DIRECT_FULL} addr_mode_t;
  typedef enum logic [1:0] {REGION_CTL, REGION_RAM, REGION_UNIMPL, REGION_WINDOW} region_t;
  typedef enum logic {WIDEN_SIGN, WIDEN_UNSIGNED} widen_op_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    access_size_t size;
    logic [`ADDR_W-1:0] pointer;
    logic [`ADDR_W-1:0] direct;
  } gen_req_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] effective_address;
    logic [`ADDR_W-1:0] next_pointer;
    logic misaligned;
    region_t region;
  } gen_res_t;

  typedef struct packed {
    logic valid;
    widen_op_t op;
    logic [15:0] value;
  } widen_req_t;

  typedef struct packed {
    logic strobe_lo;
    logic strobe_hi;
    logic [`ADDR_W-1:0] addr;
    logic [15:0] data;
  } ctl_wr_t;

  // ==========================================================
  // functions
  function automatic logic [`ADDR_W-1:0] step_for(access_size_t size);
    return (size == SIZE_BYTE) ? `BYTE_STEP : `WORD_STEP;
  endfunction

  function automatic region_t region_of(logic [`ADDR_W-1:0] eff_addr);
    if (eff_addr[`WINDOW_BIT]) return REGION_WINDOW;
    if (eff_addr <= `CTL_END) return REGION_CTL;
    if (eff_addr <= `RAM_END) return REGION_RAM;
    return REGION_UNIMPL;
  endfunction

  function automatic logic [15:0] pick_lane(logic [15:0] word, access_size_t size, logic odd);
    if (size == SIZE_WORD) return word;
    return {8'h00, odd ? word[15:8] : word[7:0]};
  endfunction

endpackage

`default_nettype wire

// ==== address_generator.sv ====
// effective address generator with post-increment and region decode
`default_nettype none
`include "data_space_defs.svh"

module address_generator #(
  parameter bit ALLOW_BITREV = 1'b0
) (
  input wire data_space_pkg::gen_req_t req,
  input wire logic bitrev_req,
  input wire logic [`ADDR_W-1:0] bitrev_next,
  output data_space_pkg::gen_res_t res
);

  // ==========================================================
  // effective address
  wire logic [`ADDR_W-1:0] near_addr = {3'h0, req.direct[`NEAR_FIELD_W-1:0]};
  wire logic [`ADDR_W-1:0] eff_addr =
    (req.mode == data_space_pkg::MODE_DIRECT_NEAR) ? near_addr :
    (req.mode == data_space_pkg::MODE_DIRECT_FULL) ? req.direct :
    req.pointer;

  // ==========================================================
  // post-modify; reversed carry only where the instance allows it
  wire logic use_bitrev = ALLOW_BITREV && bitrev_req;
  wire logic [`ADDR_W-1:0] stepped = req.pointer + data_space_pkg::step_for(req.size);
  wire logic [`ADDR_W-1:0] next_ptr =
    (req.mode != data_space_pkg::MODE_POSTINC) ? req.pointer :
    use_bitrev ? bitrev_next : stepped;

  assign res.effective_address = eff_addr;
  assign res.next_pointer = next_ptr;
  assign res.misaligned = req.valid && (req.size == data_space_pkg::SIZE_WORD) && eff_addr[0];
  assign res.region = data_space_pkg::region_of(eff_addr);

endmodule // address_generator

`default_nettype wire

// ==== data_space_access_monitor.sv ====
// assertion checker for the data space access unit
`default_nettype none
module data_space_access_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire data_space_pkg::gen_req_t x_rd_req,
  input wire data_space_pkg::gen_req_t y_rd_req,
  input wire data_space_pkg::gen_req_t wr_req,
  input wire data_space_pkg::widen_req_t widen_req,
  input wire logic x_rd_valid,
  input wire logic [15:0] x_rd_data,
  input wire logic x_window_hit,
  input wire logic [15:0] x_next_ptr,
  input wire logic y_rd_valid,
  input wire logic [15:0] y_rd_data,
  input wire logic wr_done,
  input wire data_space_pkg::ctl_wr_t ctl_wr,
  input wire logic addr_error,
  input wire logic addr_error_is_write,
  input wire logic widen_valid,
  input wire logic [15:0] widen_result
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // sequences
  sequence s_odd_wr;
    wr_req.valid && wr_req.size == data_space_pkg::SIZE_WORD && wr_req.direct[0]
      && wr_req.mode == data_space_pkg::MODE_DIRECT_FULL;
  endsequence
  sequence s_trap_wr;
    addr_error && addr_error_is_write && wr_done && !ctl_wr.strobe_lo && !ctl_wr.strobe_hi;
  endsequence
  sequence s_ctl_byte;
    wr_req.valid && wr_req.size == data_space_pkg::SIZE_BYTE && wr_req.direct <= 16'h07ff
      && wr_req.mode == data_space_pkg::MODE_DIRECT_FULL;
  endsequence
  // ==========================================================
  // properties
  property p_odd_wr; s_odd_wr |=> s_trap_wr; endproperty
  property p_ctl_lane;
    s_ctl_byte |=> ctl_wr.strobe_hi == $past(wr_req.direct[0])
      && ctl_wr.strobe_lo == !$past(wr_req.direct[0]);
  endproperty
  property p_x_ack; x_rd_req.valid |=> x_rd_valid; endproperty
  property p_y_ack; y_rd_req.valid |=> y_rd_valid; endproperty
  property p_quiet; !x_rd_req.valid && !y_rd_req.valid && !wr_req.valid |=> !addr_error; endproperty
  property p_pinc;
    x_rd_req.mode == data_space_pkg::MODE_POSTINC && x_rd_req.size == data_space_pkg::SIZE_BYTE
      |=> x_next_ptr == $past(x_rd_req.pointer) + 16'h0001;
  endproperty
  property p_win;
    x_rd_req.valid && x_rd_req.mode == data_space_pkg::MODE_DIRECT_FULL && x_rd_req.direct[15]
      |=> x_window_hit && x_rd_data == 16'h0000;
  endproperty
  property p_sext;
    widen_req.valid && widen_req.op == data_space_pkg::WIDEN_SIGN |=> widen_valid
      && widen_result == {{8{$past(widen_req.value[7])}}, $past(widen_req.value[7:0])};
  endproperty
  property p_y_low;
    y_rd_req.valid && y_rd_req.mode == data_space_pkg::MODE_DIRECT_FULL
      && y_rd_req.direct < 16'h4800 |=> y_rd_data == 16'h0000;
  endproperty
  a_odd_wr: assert property (p_odd_wr) else $error("misaligned write not trapped");
  a_ctl_lane: assert property (p_ctl_lane) else $error("wrong byte lane strobe");
  a_x_ack: assert property (p_x_ack) else $error("x read not answered");
  a_y_ack: assert property (p_y_ack) else $error("y read not answered");
  a_quiet: assert property (p_quiet) else $error("address error without access");
  a_pinc: assert property (p_pinc) else $error("byte post increment wrong");
  a_win: assert property (p_win) else $error("window read not zero");
  a_sext: assert property (p_sext) else $error("sign widen wrong");
  a_y_low: assert property (p_y_low) else $error("y read below boundary not zero");
endmodule // data_space_access_monitor

bind data_space_access data_space_access_monitor mon (.*);
`default_nettype wire

// ==== ctl_reg_model.sv ====
// one control register standing in for the core's register file
`default_nettype none
module ctl_reg_model #(
  parameter logic [15:0] REG_ADDR = 16'h0020
) (
  input wire logic clk,
  input wire data_space_pkg::gen_req_t x_rd_req,
  input wire data_space_pkg::ctl_wr_t ctl_wr,
  output logic ctl_rd_hit,
  output logic [15:0] ctl_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] value_reg = 16'h0000;
  wire logic [15:0] rd_addr = x_rd_req.mode == data_space_pkg::MODE_DIRECT_NEAR ?
    {3'b000, x_rd_req.direct[12:0]} : x_rd_req.mode == data_space_pkg::MODE_DIRECT_FULL ?
    x_rd_req.direct : x_rd_req.pointer;
  assign ctl_rd_hit = rd_addr[15:1] == REG_ADDR[15:1];
  // unselected data is not left at the last value
  assign ctl_rd_data = ctl_rd_hit ? value_reg : ~value_reg;
  always @(posedge clk) begin
    if (ctl_wr.addr[15:1] == REG_ADDR[15:1]) begin
      if (ctl_wr.strobe_lo) value_reg[7:0] <= ctl_wr.data[7:0];
      if (ctl_wr.strobe_hi) value_reg[15:8] <= ctl_wr.data[15:8];
    end
  end
endmodule // ctl_reg_model
`default_nettype wire

// ==== test_data_space_access.sv ====
// self-checking bench for the data space access unit
`default_nettype none
module test_data_space_access;
  timeunit 1ns;
  timeprecision 1ns;
  typedef data_space_pkg::gen_req_t req_t;
  localparam data_space_pkg::addr_mode_t DF = data_space_pkg::MODE_DIRECT_FULL;
  localparam data_space_pkg::addr_mode_t DN = data_space_pkg::MODE_DIRECT_NEAR;
  localparam data_space_pkg::addr_mode_t PI = data_space_pkg::MODE_POSTINC;
  localparam data_space_pkg::access_size_t B = data_space_pkg::SIZE_BYTE;
  localparam data_space_pkg::access_size_t W = data_space_pkg::SIZE_WORD;
  localparam req_t NOP = '0;
  logic clk, rstn, wr_bitrev, x_rd_valid, x_window_hit, y_rd_valid, wr_done, addr_error;
  logic addr_error_is_write, widen_valid, ctl_rd_hit;
  logic [15:0] wr_data, wr_bitrev_next, wreg_old, ctl_rd_data, x_rd_data, x_load_value;
  logic [15:0] x_next_ptr, y_rd_data, y_next_ptr, wr_next_ptr, widen_result;
  req_t x_rd_req, y_rd_req, wr_req;
  data_space_pkg::widen_req_t widen_req;
  data_space_pkg::ctl_wr_t ctl_wr;
  int fail_count, check_count;

  data_space_access dut (.*);
  ctl_reg_model partner (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic req_t rq(data_space_pkg::addr_mode_t m, data_space_pkg::access_size_t s,
                              logic [15:0] a);
    return '{1'b1, m, s, a, a};
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one request cycle, answers sampled after the taking edge
  task automatic cyc(req_t x, req_t y, req_t w, logic [15:0] d);
    @(posedge clk);
    x_rd_req <= x;
    y_rd_req <= y;
    wr_req <= w;
    wr_data <= d;
    @(posedge clk);
    x_rd_req <= NOP;
    y_rd_req <= NOP;
    wr_req <= NOP;
    #1;
  endtask

  task automatic wid(data_space_pkg::widen_op_t op, logic [15:0] v, logic [15:0] e);
    @(posedge clk);
    widen_req <= '{1'b1, op, v};
    @(posedge clk);
    widen_req <= '0;
    #1;
    chk(16'(widen_valid), 16'h0001);
    chk(widen_result, e);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_ram;
    cyc(NOP, NOP, rq(DF, W, 16'h0900), 16'hbeef);
    chk(16'(wr_done), 16'h0001);
    cyc(rq(PI, B, 16'h0901), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'h00be);
    chk(x_load_value, 16'hc3be);
    chk(x_next_ptr, 16'h0902);
    cyc(NOP, NOP, rq(DF, B, 16'h0900), 16'h775a);
    cyc(rq(PI, W, 16'h0900), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'hbe5a);
    chk(x_next_ptr, 16'h0902);
    cyc(rq(DN, W, 16'he900), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'hbe5a);
    @(posedge clk);
    wr_bitrev <= 1'b1;
    cyc(NOP, NOP, rq(PI, W, 16'h0902), 16'h1111);
    chk(wr_next_ptr, 16'h0abc);
    wr_bitrev <= 1'b0;
    cyc(NOP, NOP, rq(PI, B, 16'h0905), 16'h0033);
    chk(wr_next_ptr, 16'h0906);
    cyc(rq(DF, W, 16'h0902), NOP, rq(DF, W, 16'h0902), 16'h2222);
    chk(x_rd_data, 16'h1111);
    cyc(rq(DF, W, 16'h0902), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'h2222);
    $display("t_ram done");
  endtask

  task automatic t_mis;
    cyc(NOP, NOP, rq(DF, W, 16'h0901), 16'hdead);
    chk(16'({addr_error, addr_error_is_write, wr_done}), 16'h0007);
    cyc(rq(DF, W, 16'h0901), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'hbe5a);
    chk(16'({addr_error, addr_error_is_write}), 16'h0002);
    @(posedge clk);
    #1;
    chk(16'(addr_error), 16'h0000);
    $display("t_mis done");
  endtask

  task automatic t_zero;
    cyc(NOP, NOP, rq(DF, W, 16'h7800), 16'hffff);
    cyc(rq(DF, W, 16'h7800), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'h0000);
    cyc(rq(DF, W, 16'h8000), NOP, NOP, 16'h0000);
    chk(16'(x_window_hit), 16'h0001);
    chk(x_rd_data, 16'h0000);
    cyc(rq(DF, W, 16'h0100), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'h0000);
    cyc(NOP, NOP, rq(DF, W, 16'h0020), 16'h1234);
    cyc(NOP, NOP, rq(DF, B, 16'h0021), 16'h00ab);
    cyc(rq(DF, W, 16'h0020), NOP, NOP, 16'h0000);
    chk(x_rd_data, 16'hab34);
    $display("t_zero done");
  endtask

  task automatic t_xy;
    cyc(NOP, NOP, rq(DF, W, 16'h4800), 16'h4848);
    cyc(rq(DF, W, 16'h0900), rq(PI, W, 16'h4800), NOP, 16'h0000);
    chk(16'({x_rd_valid, y_rd_valid}), 16'h0003);
    chk(x_rd_data, 16'hbe5a);
    chk(y_rd_data, 16'h4848);
    chk(y_next_ptr, 16'h4802);
    cyc(NOP, rq(DF, W, 16'h0900), NOP, 16'h0000);
    chk(y_rd_data, 16'h0000);
    wid(data_space_pkg::WIDEN_SIGN, 16'h3380, 16'hff80);
    wid(data_space_pkg::WIDEN_SIGN, 16'hc07f, 16'h007f);
    wid(data_space_pkg::WIDEN_UNSIGNED, 16'hab80, 16'h0080);
    $display("t_xy done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (600) @(posedge clk);
    fail_count++;
    end_sim;
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    rstn = 1'b0;
    {x_rd_req, y_rd_req, wr_req, widen_req} = '0;
    {wr_data, wr_bitrev} = '0;
    wr_bitrev_next = 16'h0abc;
    wreg_old = 16'hc300;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'({x_rd_valid, wr_done, addr_error}), 16'h0000);
    t_ram;
    t_mis;
    t_zero;
    t_xy;
    end_sim;
  end
endmodule // test_data_space_access
`default_nettype wire
